// ==== mta_pkg.sv ====
package mta_pkg;

    // ------------------------------------------------------------
    // Register window
    // ------------------------------------------------------------
    localparam logic [15:0] ENTRY_W1_OFS = 16'h0420;
    localparam logic [15:0] ENTRY_W2_OFS = 16'h0424;
    localparam logic [15:0] ENTRY_W3_OFS = 16'h0428;
    localparam logic [15:0] ENTRY_W4_OFS = 16'h042C;
    localparam logic [31:0] WORD_RESET = 32'h00000000;

    // Writable bits; reserved bits stay zero
    localparam logic [31:0] W1_MASK = 32'hFC000007;
    localparam logic [31:0] HSH_W2_MASK = 32'h8000003F;
    localparam logic [31:0] STA_W2_MASK = 32'hC000003F;
    localparam logic [31:0] W3_MASK = 32'h007FFFFF;
    localparam logic [31:0] W4_MASK = 32'hFFFFFFFF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STATIC_BIT = 31;
    localparam int SRC_DROP_BIT = 30;
    localparam int DST_DROP_BIT = 29;
    localparam int PRIO_LSB = 26;
    localparam int MSTP_LSB = 0;
    localparam int OVERRIDE_BIT = 31;
    localparam int USE_FID_BIT = 30;
    localparam int PORTS_LSB = 0;
    localparam int FID_LSB = 16;
    localparam int MAC_HI_LSB = 0;

    // ------------------------------------------------------------
    // Sizes, aging, commands
    // ------------------------------------------------------------
    localparam int STA_ENTRIES = 16;
    localparam int NUM_PORTS = 6;
    localparam logic [2:0] AGE_RELOAD = 3'h7;
    localparam logic TBL_STATIC = 1'h0;
    localparam logic TBL_HASHED = 1'h1;
    localparam logic [1:0] HSH_ACT_WRITE = 2'h1;
    localparam logic [1:0] HSH_ACT_READ = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_STAT = 3'h2,
        ST_HASH = 3'h4
    } mta_state_type;

endpackage : mta_pkg

// ==== mta_stat_if.sv ====
`timescale 1ns/1ns
interface mta_stat_if;
    logic wr_en;
    logic [3:0] slot;
    logic [3:0][31:0] wr_w;
    logic [3:0][31:0] rd_w;
    logic [47:0] lk_mac;
    logic [6:0] lk_fid;
    logic lk_hit;
    logic [31:0] lk_w1;
    logic [31:0] lk_w2;

    modport owner (output wr_en, output slot, output wr_w, input rd_w,
                   output lk_mac, output lk_fid, input lk_hit, input lk_w1, input lk_w2);
    modport store (input wr_en, input slot, input wr_w, output rd_w,
                   input lk_mac, input lk_fid, output lk_hit, output lk_w1, output lk_w2);
endinterface : mta_stat_if

// ==== mta_stat_table.sv ====
`timescale 1ns/1ns
module mta_stat_table (
    input wire logic ref_clk,
    input wire logic rst,
    mta_stat_if.store st
);

    logic [3:0][31:0] mem_r [mta_pkg::STA_ENTRIES];

    // ------------------------------------------------------------
    // Storage, host writes only, no aging path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < mta_pkg::STA_ENTRIES; i++) begin
                mem_r[i] <= '0;
            end
        end else if (st.wr_en) begin
            mem_r[st.slot] <= st.wr_w;
        end
    end

    assign st.rd_w = mem_r[st.slot];

    // ------------------------------------------------------------
    // Parallel search, lowest slot wins
    // ------------------------------------------------------------
    always_comb begin
        st.lk_hit = 1'b0;
        st.lk_w1 = '0;
        st.lk_w2 = '0;
        for (int i = mta_pkg::STA_ENTRIES - 1; i >= 0; i--) begin
            if (mem_r[i][0][mta_pkg::STATIC_BIT] &&
                mem_r[i][3] == st.lk_mac[31:0] &&
                mem_r[i][2][15:0] == st.lk_mac[47:32] &&
                (!mem_r[i][1][mta_pkg::USE_FID_BIT] ||
                 mem_r[i][2][22:16] == st.lk_fid)) begin
                st.lk_hit = 1'b1;
                st.lk_w1 = mem_r[i][0];
                st.lk_w2 = mem_r[i][1];
            end
        end
    end

    store_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        st.wr_en |=> mem_r[$past(st.slot)] == $past(st.wr_w))
        else $error("static slot not written");

endmodule : mta_stat_table

// ==== mta_entry_access.sv ====
`timescale 1ns/1ns
// Function
// - Word 1 bit 31 set means host entry, never aged.
// - Word 1 bit 30 drops packets whose source address matches a hashed entry.
// - Word 1 bit 29 drops packets whose destination address matches.
// - Bits 28:26 are priority for host entries and static table.
// - Dynamic entries: bits 28:26 age, reloaded on touch, decremented per pass.
// - Dynamic entry with zero age counts as invalid.
// - Word 1 bits 2:0 carry spanning tree group for matching.
// - Word 2 bit 31 lets the entry override port state.
// - Word 3 holds group id and MAC high; word 4 MAC low.
// - Static table has 16 host-written, never aged entries.
// - Destination lookup searches every table.
// - Static results beat dynamic results.
// - Device clears go bit at completion; read loads entry words.
// - Static word 1 bit 31 marks the entry valid.
module mta_entry_access (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_r,
    input wire logic cmd_go,
    input wire logic cmd_table,
    input wire logic [1:0] cmd_action,
    input wire logic [3:0] cmd_slot,
    input wire logic cmd_direct,
    output logic go_done_bit_r,
    output logic hsh_req_r,
    output logic hsh_write_r,
    output logic hsh_direct_r,
    output logic [127:0] hsh_wr_words_r,
    input wire logic hsh_ack,
    input wire logic hsh_rd_valid,
    input wire logic [127:0] hsh_rd_words,
    input wire logic lkp_valid,
    input wire logic [47:0] lkp_mac,
    input wire logic [6:0] lkp_fid,
    input wire logic hsh_hit,
    input wire logic [31:0] hsh_w1,
    input wire logic [31:0] hsh_w2,
    input wire logic src_valid,
    input wire logic hsh_src_hit,
    input wire logic [31:0] hsh_src_w1,
    output logic fwd_valid_r,
    output logic fwd_hit_r,
    output logic [5:0] fwd_ports_r,
    output logic fwd_drop_r,
    output logic fwd_override_r,
    output logic [2:0] fwd_prio_r,
    output logic [2:0] fwd_mstp_r,
    output logic src_drop_r,
    input wire logic age_touch,
    input wire logic age_pass,
    input wire logic [31:0] age_word_in,
    output logic [31:0] age_word_r
);

    mta_stat_if st ();

    mta_pkg::mta_state_type state_r;
    logic [31:0] w1_r;
    logic [31:0] w2_r;
    logic [31:0] w3_r;
    logic [31:0] w4_r;
    logic last_tbl_r;
    logic op_read_r;
    logic [3:0] slot_r;
    logic sel_hit;
    logic [31:0] sel_w1;
    logic [31:0] sel_w2;
    logic busy;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] mta_w2_mask(input logic tbl);
        return (tbl == mta_pkg::TBL_STATIC) ? mta_pkg::STA_W2_MASK : mta_pkg::HSH_W2_MASK;
    endfunction : mta_w2_mask

    // Dynamic entry is alive only while its age is nonzero
    function automatic logic mta_usable(input logic [31:0] w1);
        return w1[mta_pkg::STATIC_BIT] || (w1[mta_pkg::PRIO_LSB +: 3] != 3'h0);
    endfunction : mta_usable

    function automatic logic [31:0] mta_age_next(input logic [31:0] w1, input logic touch,
                                                 input logic pass);
        logic [31:0] r;
        r = w1;
        if (!w1[mta_pkg::STATIC_BIT]) begin
            if (touch) begin
                r[mta_pkg::PRIO_LSB +: 3] = mta_pkg::AGE_RELOAD;
            end else if (pass && w1[mta_pkg::PRIO_LSB +: 3] != 3'h0) begin
                r[mta_pkg::PRIO_LSB +: 3] = w1[mta_pkg::PRIO_LSB +: 3] - 3'h1;
            end
        end
        return r;
    endfunction : mta_age_next

    assign busy = (state_r != mta_pkg::ST_IDLE);

    // ------------------------------------------------------------
    // Operation sequencing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= mta_pkg::ST_IDLE;
            go_done_bit_r <= 1'b0;
            last_tbl_r <= mta_pkg::TBL_STATIC;
            op_read_r <= 1'b0;
            slot_r <= 4'h0;
            hsh_req_r <= 1'b0;
            hsh_write_r <= 1'b0;
            hsh_direct_r <= 1'b0;
            hsh_wr_words_r <= '0;
        end else begin
            case (state_r)
                mta_pkg::ST_IDLE: begin
                    if (cmd_go && cmd_table == mta_pkg::TBL_STATIC) begin
                        state_r <= mta_pkg::ST_STAT;
                        go_done_bit_r <= 1'b1;
                        last_tbl_r <= mta_pkg::TBL_STATIC;
                        op_read_r <= cmd_action[0];
                        slot_r <= cmd_slot;
                    end else if (cmd_go && (cmd_action == mta_pkg::HSH_ACT_READ ||
                                            cmd_action == mta_pkg::HSH_ACT_WRITE)) begin
                        state_r <= mta_pkg::ST_HASH;
                        go_done_bit_r <= 1'b1;
                        last_tbl_r <= mta_pkg::TBL_HASHED;
                        op_read_r <= (cmd_action == mta_pkg::HSH_ACT_READ);
                        hsh_req_r <= 1'b1;
                        hsh_write_r <= (cmd_action == mta_pkg::HSH_ACT_WRITE);
                        hsh_direct_r <= cmd_direct;
                        hsh_wr_words_r <= {w4_r, w3_r, w2_r, w1_r};
                    end
                end
                mta_pkg::ST_STAT: begin
                    state_r <= mta_pkg::ST_IDLE;
                    go_done_bit_r <= 1'b0;
                end
                mta_pkg::ST_HASH: begin
                    if (hsh_ack) begin
                        state_r <= mta_pkg::ST_IDLE;
                        go_done_bit_r <= 1'b0;
                        hsh_req_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= mta_pkg::ST_IDLE;
                    go_done_bit_r <= 1'b0;
                    hsh_req_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Shared entry words
    // ------------------------------------------------------------
    // Host writes are dropped while an operation owns the words
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            w1_r <= mta_pkg::WORD_RESET;
            w2_r <= mta_pkg::WORD_RESET;
            w3_r <= mta_pkg::WORD_RESET;
            w4_r <= mta_pkg::WORD_RESET;
        end else if (state_r == mta_pkg::ST_STAT && op_read_r) begin
            w1_r <= st.rd_w[0] & mta_pkg::W1_MASK;
            w2_r <= st.rd_w[1] & mta_pkg::STA_W2_MASK;
            w3_r <= st.rd_w[2] & mta_pkg::W3_MASK;
            w4_r <= st.rd_w[3];
        end else if (state_r == mta_pkg::ST_HASH && hsh_ack && op_read_r) begin
            // Miss returns all zeros
            w1_r <= hsh_rd_valid ? hsh_rd_words[31:0] & mta_pkg::W1_MASK : '0;
            w2_r <= hsh_rd_valid ? hsh_rd_words[63:32] & mta_pkg::HSH_W2_MASK : '0;
            w3_r <= hsh_rd_valid ? hsh_rd_words[95:64] & mta_pkg::W3_MASK : '0;
            w4_r <= hsh_rd_valid ? hsh_rd_words[127:96] : '0;
        end else if (reg_wr && !busy) begin
            if (reg_addr == mta_pkg::ENTRY_W1_OFS) begin
                w1_r <= reg_wdata & mta_pkg::W1_MASK;
            end else if (reg_addr == mta_pkg::ENTRY_W2_OFS) begin
                w2_r <= reg_wdata & mta_w2_mask(last_tbl_r);
            end else if (reg_addr == mta_pkg::ENTRY_W3_OFS) begin
                w3_r <= reg_wdata & mta_pkg::W3_MASK;
            end else if (reg_addr == mta_pkg::ENTRY_W4_OFS) begin
                w4_r <= reg_wdata & mta_pkg::W4_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata_r <= '0;
        end else if (reg_rd) begin
            if (reg_addr == mta_pkg::ENTRY_W1_OFS) begin
                reg_rdata_r <= w1_r;
            end else if (reg_addr == mta_pkg::ENTRY_W2_OFS) begin
                reg_rdata_r <= w2_r & mta_w2_mask(last_tbl_r);
            end else if (reg_addr == mta_pkg::ENTRY_W3_OFS) begin
                reg_rdata_r <= w3_r;
            end else if (reg_addr == mta_pkg::ENTRY_W4_OFS) begin
                reg_rdata_r <= w4_r;
            end else begin
                reg_rdata_r <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Static table
    // ------------------------------------------------------------
    assign st.wr_en = (state_r == mta_pkg::ST_STAT) && !op_read_r;
    assign st.slot = busy ? slot_r : cmd_slot;
    assign st.wr_w = {w4_r, w3_r, w2_r, w1_r};
    assign st.lk_mac = lkp_mac;
    assign st.lk_fid = lkp_fid;

    mta_stat_table u_stat (
        .ref_clk(ref_clk),
        .rst(rst),
        .st(st)
    );

    // ------------------------------------------------------------
    // Destination lookup merge
    // ------------------------------------------------------------
    // Static table first, then hashed static, then live dynamic
    always_comb begin
        sel_hit = 1'b0;
        sel_w1 = '0;
        sel_w2 = '0;
        if (st.lk_hit) begin
            sel_hit = 1'b1;
            sel_w1 = st.lk_w1;
            sel_w2 = st.lk_w2;
        end else if (hsh_hit && mta_usable(hsh_w1)) begin
            sel_hit = 1'b1;
            sel_w1 = hsh_w1;
            sel_w2 = hsh_w2;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fwd_valid_r <= 1'b0;
            fwd_hit_r <= 1'b0;
            fwd_ports_r <= '0;
            fwd_drop_r <= 1'b0;
            fwd_override_r <= 1'b0;
            fwd_prio_r <= '0;
            fwd_mstp_r <= '0;
        end else begin
            fwd_valid_r <= lkp_valid;
            fwd_hit_r <= lkp_valid && sel_hit;
            fwd_ports_r <= sel_w2[mta_pkg::PORTS_LSB +: mta_pkg::NUM_PORTS];
            fwd_drop_r <= lkp_valid && sel_hit && sel_w1[mta_pkg::DST_DROP_BIT];
            fwd_override_r <= sel_hit && sel_w2[mta_pkg::OVERRIDE_BIT];
            // Age bits carry no priority for dynamic entries
            fwd_prio_r <= sel_w1[mta_pkg::STATIC_BIT] ? sel_w1[mta_pkg::PRIO_LSB +: 3] : '0;
            fwd_mstp_r <= sel_w1[mta_pkg::MSTP_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // Source filter and aging
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_drop_r <= 1'b0;
        end else begin
            src_drop_r <= src_valid && hsh_src_hit && hsh_src_w1[mta_pkg::SRC_DROP_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            age_word_r <= '0;
        end else begin
            age_word_r <= mta_age_next(age_word_in, age_touch, age_pass);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence stat_go_s;
        state_r == mta_pkg::ST_IDLE && cmd_go && cmd_table == mta_pkg::TBL_STATIC;
    endsequence

    go_clear_a: assert property (stat_go_s |=> go_done_bit_r ##1 !go_done_bit_r)
        else $error("go bit not cleared after static op");
    read_load_a: assert property (stat_go_s ##1 op_read_r |=>
        w1_r == ($past(st.rd_w[0]) & mta_pkg::W1_MASK))
        else $error("static read did not load word 1");
    resv_zero_a: assert property ((w1_r & ~mta_pkg::W1_MASK) == '0 && w3_r[31:23] == '0)
        else $error("reserved entry bits nonzero");
    static_prec_a: assert property (lkp_valid && st.lk_hit |=>
        fwd_hit_r && fwd_ports_r == $past(st.lk_w2[5:0]))
        else $error("static result lost precedence");
    dyn_stale_a: assert property (lkp_valid && !st.lk_hit && hsh_hit &&
        !hsh_w1[31] && hsh_w1[28:26] == 3'h0 |=> !fwd_hit_r)
        else $error("aged dynamic entry used");
    dst_drop_a: assert property (lkp_valid && st.lk_hit && st.lk_w1[29] |=> fwd_drop_r)
        else $error("destination filter not applied");
    src_drop_a: assert property (src_valid && hsh_src_hit |=>
        src_drop_r == $past(hsh_src_w1[30]))
        else $error("source filter mismatch");
    age_reload_a: assert property (age_touch && !age_word_in[31] |=>
        age_word_r[28:26] == mta_pkg::AGE_RELOAD)
        else $error("age counter not reloaded");
    static_age_a: assert property (age_pass && age_word_in[31] |=>
        age_word_r == $past(age_word_in))
        else $error("host entry was aged");
    hash_go_a: assert property (state_r == mta_pkg::ST_HASH && hsh_ack |=>
        !go_done_bit_r && !hsh_req_r)
        else $error("hashed op did not finish on ack");

endmodule : mta_entry_access

// ==== mta_engine_model.sv ====
`timescale 1ns/1ns
module mta_engine_model (
    input wire logic ref_clk,
    input wire logic req,
    input wire logic [3:0] dly,
    input wire logic vld,
    input wire logic [127:0] words,
    output logic ack,
    output logic rd_valid,
    output logic [127:0] rd_words
);
    // Idle data lines carry the inverse, so a stale capture cannot match
    initial begin
        ack = 1'h0;
        rd_valid = 1'h0;
        rd_words = ~words;
    end
    always @(posedge ref_clk) begin
        #1;
        if (req === 1'h1 && ack === 1'h0) begin
            repeat (dly) begin
                @(posedge ref_clk);
                #1;
            end
            ack = 1'h1;
            rd_valid = vld;
            rd_words = words;
            @(posedge ref_clk);
            #1;
            ack = 1'h0;
            rd_valid = 1'h0;
            rd_words = ~words;
        end
    end
endmodule : mta_engine_model

// ==== tb_mac_table_entry_access.sv ====
`timescale 1ns/1ns
module tb_mac_table_entry_access;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [15:0] reg_addr;
    logic reg_wr, reg_rd, cmd_go, cmd_table, cmd_direct, hsh_ack, hsh_rd_valid;
    logic [31:0] reg_wdata, hsh_w1, hsh_w2, hsh_src_w1, age_word_in, reg_rdata_r, age_word_r, w;
    logic [1:0] cmd_action;
    logic [3:0] cmd_slot, eng_dly;
    logic [127:0] hsh_rd_words, hsh_wr_words_r, eng_words, hw_exp;
    logic lkp_valid, hsh_hit, src_valid, hsh_src_hit, age_touch, age_pass, eng_vld;
    logic [47:0] lkp_mac;
    logic [6:0] lkp_fid;
    logic go_done_bit_r, hsh_req_r, hsh_write_r, hsh_direct_r, fwd_valid_r, fwd_hit_r;
    logic fwd_drop_r, fwd_override_r, src_drop_r, rd_s, lk_s, sr_s, ag_s;
    logic [5:0] fwd_ports_r;
    logic [2:0] fwd_prio_r, fwd_mstp_r;
    logic [15:0] fe, fv;
    logic [31:0] sw [16][4];
    logic [31:0] q_rd [$];
    logic [15:0] q_fwd [$];
    logic q_src [$];
    logic [31:0] q_age [$];
    int n_fail = 0, total_checks = 0, seed = 63, i, s;

    always #25 ref_clk = ~ref_clk;

    mta_entry_access dut_u (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r,
        .cmd_go, .cmd_table, .cmd_action, .cmd_slot, .cmd_direct, .go_done_bit_r, .hsh_req_r,
        .hsh_write_r, .hsh_direct_r, .hsh_wr_words_r, .hsh_ack, .hsh_rd_valid, .hsh_rd_words,
        .lkp_valid, .lkp_mac, .lkp_fid, .hsh_hit, .hsh_w1, .hsh_w2, .src_valid, .hsh_src_hit,
        .hsh_src_w1, .fwd_valid_r, .fwd_hit_r, .fwd_ports_r, .fwd_drop_r, .fwd_override_r,
        .fwd_prio_r, .fwd_mstp_r, .src_drop_r, .age_touch, .age_pass, .age_word_in, .age_word_r);

    mta_engine_model eng_u (.ref_clk, .req(hsh_req_r), .dly(eng_dly), .vld(eng_vld),
        .words(eng_words), .ack(hsh_ack), .rd_valid(hsh_rd_valid), .rd_words(hsh_rd_words));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [15:0] ofs(input int k);
        return mta_pkg::ENTRY_W1_OFS + 16'(4 * k);
    endfunction : ofs

    function logic [31:0] msk(input logic tb, input int k);
        case (k)
            0: return mta_pkg::W1_MASK;
            1: return tb ? mta_pkg::HSH_W2_MASK : mta_pkg::STA_W2_MASK;
            2: return mta_pkg::W3_MASK;
            default: return mta_pkg::W4_MASK;
        endcase
    endfunction : msk

    task check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'h0;
        reg_wdata = ~d;
    endtask : wr

    task rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'h1;
        q_rd.push_back(e);
        @(posedge ref_clk);
        #1;
        reg_rd = 1'h0;
    endtask : rd

    task cmd(input logic tb, input logic [1:0] a, input logic [3:0] sl);
        int k;
        logic [2:0] rq;
        @(posedge ref_clk);
        #1;
        cmd_go = 1'h1;
        cmd_table = tb;
        cmd_action = a;
        cmd_slot = sl;
        cmd_direct = 1'($random(seed));
        @(posedge ref_clk);
        #1;
        cmd_go = 1'h0;
        if (tb && a[0] == a[1]) check("go_ignored", go_done_bit_r, 1'h0);
        else check("go_busy", go_done_bit_r, 1'h1);
        if (tb && a == mta_pkg::HSH_ACT_WRITE) check("wr_words", hsh_wr_words_r, hw_exp);
        rq = {hsh_req_r, hsh_write_r, hsh_direct_r};
        if (tb && a[0] != a[1]) check("hsh_req", rq, {1'h1, a[0], cmd_direct});
        for (k = 0; k < 40 && go_done_bit_r !== 1'h0; k++) begin
            @(posedge ref_clk);
            #1;
        end
        check("go_done", go_done_bit_r, 1'h0);
    endtask : cmd

    task lk(input logic [47:0] m, input logic [6:0] f, input logic h, input logic [31:0] w1,
            input logic [31:0] w2, input logic sh, input logic [31:0] sw1);
        logic [15:0] e;
        e = 16'h8000;
        // Descending scan: the lowest matching slot is written last and wins
        for (int k = 15; k >= 0; k--)
            if (sw[k][0][31] && {sw[k][2][15:0], sw[k][3]} == m &&
                (!sw[k][1][30] || sw[k][2][22:16] == f))
                e = {2'h1, sw[k][1][5:0], sw[k][0][29], sw[k][1][31], sw[k][0][28:26],
                     sw[k][0][2:0]};
        if (e[15] && h && (w1[31] || w1[28:26] != 3'h0))
            e = {2'h1, w2[5:0], w1[29], w2[31], w1[31] ? w1[28:26] : 3'h0, w1[2:0]};
        @(posedge ref_clk);
        #1;
        {lkp_valid, lkp_mac, lkp_fid, hsh_hit, hsh_w1, hsh_w2} = {1'h1, m, f, h, w1, w2};
        {src_valid, hsh_src_hit, hsh_src_w1} = {1'h1, sh, sw1};
        q_fwd.push_back(e);
        q_src.push_back(sh & sw1[30]);
        @(posedge ref_clk);
        #1;
        {lkp_valid, lkp_mac, hsh_w1, hsh_w2} = {1'h0, ~m, ~w1, ~w2};
        {src_valid, hsh_src_w1} = {1'h0, ~sw1};
    endtask : lk

    task age(input logic tc, input logic [31:0] aw);
        logic [31:0] e;
        e = aw;
        if (!aw[31] && tc) e[28:26] = mta_pkg::AGE_RELOAD;
        else if (!aw[31] && aw[28:26] != 3'h0) e[28:26] = aw[28:26] - 3'h1;
        @(posedge ref_clk);
        #1;
        {age_touch, age_pass, age_word_in} = {tc, !tc, aw};
        q_age.push_back(e);
        @(posedge ref_clk);
        #1;
        {age_touch, age_pass, age_word_in} = {2'h0, ~aw};
    endtask : age

    // ------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        {rd_s, lk_s, sr_s, ag_s} = {reg_rd, lkp_valid, src_valid, age_touch | age_pass};
        #5;
        if (rd_s === 1'h1) check("rdata", reg_rdata_r, q_rd.pop_front());
        if (lk_s === 1'h1) begin
            fe = q_fwd.pop_front();
            fv = {1'h0, fwd_hit_r, fwd_ports_r, fwd_drop_r, fwd_override_r, fwd_prio_r,
                  fwd_mstp_r};
            check("fwd_valid", fwd_valid_r, 1'h1);
            if (fe[15]) check("fwd_miss", fwd_hit_r, 1'h0);
            else check("fwd", fv, fe);
        end else check("fwd_idle", fwd_valid_r, 1'h0);
        if (sr_s === 1'h1) check("src_drop", src_drop_r, q_src.pop_front());
        if (ag_s === 1'h1) check("age_word", age_word_r, q_age.pop_front());
    end

    // Whole run is about 500 cycles; this allows ample margin
    initial begin
        #1000000;
        n_fail++;
        print_verdict;
    end

    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata, cmd_go, cmd_table, cmd_action, cmd_slot} = '0;
        {cmd_direct, lkp_valid, lkp_mac, lkp_fid, hsh_hit, hsh_w1, hsh_w2, src_valid} = '0;
        {hsh_src_hit, hsh_src_w1, age_touch, age_pass, age_word_in, eng_dly, eng_vld} = '0;
        {eng_words, hw_exp} = '0;
        repeat (6) @(posedge ref_clk);
        #1;
        rst = 1'h0;
        cmd(mta_pkg::TBL_STATIC, 2'h1, 4'h0);
        for (i = 0; i < 4; i++) rd(ofs(i), 32'h00000000);
        rd(16'h0430, 32'h00000000);
        $display("Test reset done");
        for (s = 0; s < 16; s++) begin
            for (i = 0; i < 4; i++) begin
                w = $random(seed);
                wr(ofs(i), w);
                sw[s][i] = w & msk(1'h0, i);
            end
            cmd(mta_pkg::TBL_STATIC, 2'h0, 4'(s));
        end
        for (s = 15; s >= 0; s--) begin
            cmd(mta_pkg::TBL_STATIC, 2'h1, 4'(s));
            for (i = 0; i < 4; i++) rd(ofs(i), sw[s][i]);
        end
        wr(ofs(1), 32'hFFFFFFFF);
        rd(ofs(1), mta_pkg::STA_W2_MASK);
        wr(16'h0430, 32'hFFFFFFFF);
        rd(16'h0430, 32'h00000000);
        $display("Test static table done");
        for (i = 0; i < 24; i++) begin
            s = $random(seed) & 15;
            w = $random(seed);
            if (i % 4 == 0) w[31:26] = 6'h00;
            lk(i % 3 == 0 ? 48'($random(seed)) : {sw[s][2][15:0], sw[s][3]}, sw[s][2][22:16],
               1'($random(seed)), w, $random(seed), 1'($random(seed)), $random(seed));
        end
        $display("Test lookup done");
        for (i = 0; i < 8; i++) begin
            w = $random(seed) & mta_pkg::W1_MASK;
            w[31] = (i == 1);
            if (i == 2) w[28:26] = 3'h0;
            age(i % 3 == 0, w);
        end
        $display("Test aging done");
        {eng_dly, eng_vld} = {4'h5, 1'h1};
        eng_words = {$random(seed), $random(seed), $random(seed), $random(seed)};
        cmd(mta_pkg::TBL_HASHED, mta_pkg::HSH_ACT_READ, 4'h0);
        for (i = 0; i < 4; i++) rd(ofs(i), eng_words[32 * i +: 32] & msk(1'h1, i));
        {eng_dly, eng_vld} = {4'h0, 1'h0};
        cmd(mta_pkg::TBL_HASHED, mta_pkg::HSH_ACT_READ, 4'h0);
        for (i = 0; i < 4; i++) rd(ofs(i), 32'h00000000);
        wr(ofs(1), 32'hFFFFFFFF);
        rd(ofs(1), mta_pkg::HSH_W2_MASK);
        for (i = 0; i < 4; i++) begin
            w = $random(seed);
            wr(ofs(i), w);
            hw_exp[32 * i +: 32] = w & msk(1'h1, i);
        end
        cmd(mta_pkg::TBL_HASHED, mta_pkg::HSH_ACT_WRITE, 4'h0);
        cmd(mta_pkg::TBL_HASHED, 2'h0, 4'h0);
        cmd(mta_pkg::TBL_HASHED, 2'h3, 4'h0);
        $display("Test hashed access done");
        print_verdict;
    end
endmodule : tb_mac_table_entry_access
